/* File: core/udmc_consts.svh */
`ifndef UDMC_CONSTS_SVH
`define UDMC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define UDMC_ADR_W 8
`define UDMC_OFS_MAIN_CTRL 8'h00
`define UDMC_OFS_IRQ_STATUS 8'h04
`define UDMC_OFS_IRQ_MASK 8'h08
`define UDMC_MAIN_CTRL_RESET 8'h00
`define UDMC_IRQ_MASK_RESET 6'h00

// ----------------------------------------------------------------------------
// Event bits of the status and mask registers
// ----------------------------------------------------------------------------
`define UDMC_EV_W 6
`define UDMC_EV_CTRL_RST_DONE 0
`define UDMC_EV_BUS_RST_DONE 1
`define UDMC_EV_FLUSH_DONE 2
`define UDMC_EV_WAKEUP 3
`define UDMC_EV_USB_BUS_RESET 4
`define UDMC_EV_SPEED_CHANGE 5

// ----------------------------------------------------------------------------
// Reset pulse lengths in clock cycles
// ----------------------------------------------------------------------------
`define UDMC_CTRL_RST_CYCLES 16
`define UDMC_BUS_RST_CYCLES 8

`endif

/* File: core/udmc_pkg.sv */
package udmc_pkg;

  // --------------------------------------------------------------------------
  // Main control register layout, bit 7 first
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic bus_side_reset;
    logic high_speed_status;
    logic fifo_write_enable;
    logic controller_soft_reset;
    logic enter_suspend;
    logic global_irq_enable;
    logic flush;
    logic remote_wakeup_capable;
  } udmc_ctrl_type;

  // --------------------------------------------------------------------------
  // Link-side inputs
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic high_speed;
    logic usb_bus_reset;
    logic wakeup;
  } udmc_link_type;

  // --------------------------------------------------------------------------
  // Reset sequencer states
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RS_IDLE = 2'b00,
    RS_RUN = 2'b01,
    RS_DONE = 2'b10
  } udmc_rst_state_type;

endpackage

/* File: core/udmc_sync.sv */
`timescale 1ns/100ps

module udmc_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else if (clk_en_i) begin
      stage1_q <= d_i;
      stage2_q <= stage1_q;
    end
  end

  assign q_o = stage2_q;

endmodule

/* File: core/udmc_reset_seq.sv */
`timescale 1ns/100ps

module udmc_reset_seq #(
  parameter int CYCLES = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic start_i,
  output logic active_o,
  output logic done_o
);

  localparam int CW = $clog2(CYCLES + 1);

  udmc_pkg::udmc_rst_state_type state_q;
  udmc_pkg::udmc_rst_state_type state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      udmc_pkg::RS_IDLE: begin
        if (start_i) begin
          state_d = udmc_pkg::RS_RUN;
          cnt_d = CW'(CYCLES - 1);
        end
      end
      udmc_pkg::RS_RUN: begin
        if (cnt_q == '0) begin
          state_d = udmc_pkg::RS_DONE;
        end else begin
          cnt_d = cnt_q - CW'(1);
        end
      end
      udmc_pkg::RS_DONE: begin
        state_d = udmc_pkg::RS_IDLE;
      end
      default: begin
        state_d = udmc_pkg::RS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= udmc_pkg::RS_IDLE;
      cnt_q <= '0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign active_o = (state_q == udmc_pkg::RS_RUN);
  assign done_o = (state_q == udmc_pkg::RS_DONE);

endmodule

/* File: core/udmc_main_control.sv */
`timescale 1ns/100ps
`include "udmc_consts.svh"

// Contract
// - Bus-side reset bit resets slave, buffer, control.
// - Hardware reset clears the bus-side reset bit.
// - Speed bit reads one in high speed.
// - Packet FIFO writes only after enable set.
// - Controller reset bit starts whole controller reset.
// - Controller reset refused while suspended.
// - Controller reset drops the power-save output.
// - Controller reset aborts any chirp sequence.
// - Controller reset clears the command FIFO.
// - Controller reset clears frame, timer, micro-frame.
// - Controller reset keeps data FIFO state.
// - Enter-suspend bit places controller in suspend.
// - Interrupt needs global enable and unmasked source.
// - Flush bit moves buffer; hardware clears it.
// - Wakeup leaves suspend when remote wakeup capable.
module udmc_main_control #(
  parameter int CTRL_RST_CYCLES = `UDMC_CTRL_RST_CYCLES,
  parameter int BUS_RST_CYCLES = `UDMC_BUS_RST_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [`UDMC_ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic high_speed_i,
  input wire logic usb_bus_reset_i,
  input wire logic wakeup_i,
  input wire logic flush_done_i,
  output logic bus_side_reset_o,
  output logic controller_soft_reset_o,
  output logic chirp_abort_o,
  output logic cmd_fifo_clear_o,
  output logic sof_clear_o,
  output logic power_save_o,
  output logic suspend_o,
  output logic fifo_write_enable_o,
  output logic flush_req_o,
  output logic irq_o
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic rst_sync_n;

  // The reset release runs even with the clock enable low, so that a frozen
  // block still leaves reset cleanly once the enable returns.
  udmc_sync #(
    .W(1)
  ) u_rst_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(1'b1),
    .d_i(1'b1),
    .q_o(rst_sync_n)
  );

  // --------------------------------------------------------------------------
  // Link input synchronisers and edge detection
  // --------------------------------------------------------------------------
  udmc_pkg::udmc_link_type link_raw;
  udmc_pkg::udmc_link_type link_s;
  udmc_pkg::udmc_link_type link_prev_q;
  udmc_pkg::udmc_link_type link_prev_d;
  logic wake_rise;
  logic bus_reset_rise;
  logic speed_change;

  assign link_raw = '{high_speed: high_speed_i, usb_bus_reset: usb_bus_reset_i, wakeup: wakeup_i};

  udmc_sync #(
    .W($bits(udmc_pkg::udmc_link_type))
  ) u_link_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_sync_n),
    .clk_en_i(clk_en_i),
    .d_i(link_raw),
    .q_o(link_s)
  );

  always_comb begin
    link_prev_d = link_s;
    wake_rise = link_s.wakeup & ~link_prev_q.wakeup;
    bus_reset_rise = link_s.usb_bus_reset & ~link_prev_q.usb_bus_reset;
    speed_change = link_s.high_speed ^ link_prev_q.high_speed;
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      link_prev_q <= '0;
    end else if (clk_en_i) begin
      link_prev_q <= link_prev_d;
    end
  end

  // --------------------------------------------------------------------------
  // Wishbone slave
  // --------------------------------------------------------------------------
  udmc_pkg::udmc_ctrl_type ctrl_q;
  udmc_pkg::udmc_ctrl_type ctrl_d;
  udmc_pkg::udmc_ctrl_type wdat;
  logic [`UDMC_EV_W-1:0] status_q;
  logic [`UDMC_EV_W-1:0] status_d;
  logic [`UDMC_EV_W-1:0] mask_q;
  logic [`UDMC_EV_W-1:0] mask_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic acc;
  logic wr_en;
  logic rd_en;
  logic hit_main;
  logic hit_status;
  logic hit_mask;
  logic wr_main;
  logic wr_mask;
  logic rd_status;

  // Registers are decoded on whole words; the two low address bits are
  // ignored, and an unmapped word answers zero and drops writes.
  always_comb begin
    acc = wb_cyc_i & wb_stb_i & ~ack_q;
    wr_en = acc & wb_we_i & wb_sel_i[0];
    rd_en = acc & ~wb_we_i;
    hit_main = (wb_adr_i[`UDMC_ADR_W-1:2] == (`UDMC_ADR_W-2)'(`UDMC_OFS_MAIN_CTRL >> 2));
    hit_status = (wb_adr_i[`UDMC_ADR_W-1:2] == (`UDMC_ADR_W-2)'(`UDMC_OFS_IRQ_STATUS >> 2));
    hit_mask = (wb_adr_i[`UDMC_ADR_W-1:2] == (`UDMC_ADR_W-2)'(`UDMC_OFS_IRQ_MASK >> 2));
    wr_main = wr_en & hit_main;
    wr_mask = wr_en & hit_mask;
    rd_status = rd_en & hit_status;
    wdat = wb_dat_i[7:0];
    ack_d = acc;
    rd_d = rd_q;
    if (rd_en) begin
      rd_d = 32'h0000_0000;
      if (hit_main) begin
        rd_d[7:0] = ctrl_q;
      end
      if (hit_status) begin
        rd_d[`UDMC_EV_W-1:0] = status_q;
      end
      if (hit_mask) begin
        rd_d[`UDMC_EV_W-1:0] = mask_q;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
    end else if (clk_en_i) begin
      ack_q <= ack_d;
      rd_q <= rd_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;

  // --------------------------------------------------------------------------
  // Reset sequencers
  // --------------------------------------------------------------------------
  logic ctrl_start;
  logic ctrl_rst_active;
  logic ctrl_rst_done;
  logic bus_start;
  logic bus_rst_active;
  logic bus_rst_done;

  // A second request while a sequence runs is dropped; the running one is
  // not restarted, so its length is always exact.
  always_comb begin
    ctrl_start = wr_main & wdat.controller_soft_reset & ~ctrl_q.enter_suspend & ~ctrl_rst_active;
    bus_start = wr_main & wdat.bus_side_reset & ~bus_rst_active;
  end

  udmc_reset_seq #(
    .CYCLES(CTRL_RST_CYCLES)
  ) u_ctrl_rst (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_sync_n),
    .clk_en_i(clk_en_i),
    .start_i(ctrl_start),
    .active_o(ctrl_rst_active),
    .done_o(ctrl_rst_done)
  );

  udmc_reset_seq #(
    .CYCLES(BUS_RST_CYCLES)
  ) u_bus_rst (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_sync_n),
    .clk_en_i(clk_en_i),
    .start_i(bus_start),
    .active_o(bus_rst_active),
    .done_o(bus_rst_done)
  );

  // --------------------------------------------------------------------------
  // Main control register
  // --------------------------------------------------------------------------
  logic wake_ok;
  logic power_save_q;
  logic power_save_d;

  always_comb begin
    ctrl_d = ctrl_q;
    wake_ok = ctrl_q.remote_wakeup_capable & ctrl_q.enter_suspend & wake_rise;
    ctrl_d.high_speed_status = link_s.high_speed;
    if (wr_main) begin
      ctrl_d.fifo_write_enable = wdat.fifo_write_enable;
      ctrl_d.global_irq_enable = wdat.global_irq_enable;
      ctrl_d.remote_wakeup_capable = wdat.remote_wakeup_capable;
      ctrl_d.enter_suspend = wdat.enter_suspend;
    end
    if (link_s.usb_bus_reset | wake_ok) begin
      ctrl_d.enter_suspend = 1'b0;
    end
    if (bus_rst_done) begin
      ctrl_d.bus_side_reset = 1'b0;
    end
    if (bus_start) begin
      ctrl_d.bus_side_reset = 1'b1;
    end
    if (ctrl_rst_done) begin
      ctrl_d.controller_soft_reset = 1'b0;
    end
    if (ctrl_start) begin
      ctrl_d.controller_soft_reset = 1'b1;
    end
    if (flush_done_i & ctrl_q.flush) begin
      ctrl_d.flush = 1'b0;
    end
    if (wr_main & wdat.flush) begin
      ctrl_d.flush = 1'b1;
    end
    power_save_d = ctrl_d.enter_suspend & ~ctrl_start & ~ctrl_rst_active;
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_q <= `UDMC_MAIN_CTRL_RESET;
      power_save_q <= 1'b0;
    end else if (clk_en_i) begin
      ctrl_q <= ctrl_d;
      power_save_q <= power_save_d;
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  logic [`UDMC_EV_W-1:0] ev;
  logic irq_q;
  logic irq_d;

  always_comb begin
    ev = '0;
    ev[`UDMC_EV_CTRL_RST_DONE] = ctrl_rst_done;
    ev[`UDMC_EV_BUS_RST_DONE] = bus_rst_done;
    ev[`UDMC_EV_FLUSH_DONE] = flush_done_i & ctrl_q.flush;
    ev[`UDMC_EV_WAKEUP] = wake_ok;
    ev[`UDMC_EV_USB_BUS_RESET] = bus_reset_rise;
    ev[`UDMC_EV_SPEED_CHANGE] = speed_change;
    status_d = status_q;
    if (rd_status) begin
      status_d = '0;
    end
    // An event in the cycle of the clearing read survives it.
    status_d = status_d | ev;
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = wb_dat_i[`UDMC_EV_W-1:0];
    end
    // gated by enable and mask
    // The level follows the next register values, so it never outlasts a cleared enable.
    irq_d = ctrl_d.global_irq_enable & (|(status_d & mask_d));
  end

  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      status_q <= '0;
      mask_q <= `UDMC_IRQ_MASK_RESET;
      irq_q <= 1'b0;
    end else if (clk_en_i) begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  assign irq_o = irq_q;

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // resets slave, buffer, control
  assign bus_side_reset_o = bus_rst_active;
  assign controller_soft_reset_o = ctrl_rst_active;
  assign chirp_abort_o = ctrl_rst_active;
  assign cmd_fifo_clear_o = ctrl_rst_active;
  assign sof_clear_o = ctrl_rst_active;
  // The controller reset has no path into the data FIFO or its enable.
  assign fifo_write_enable_o = ctrl_q.fifo_write_enable;
  assign power_save_o = power_save_q;
  assign suspend_o = ctrl_q.enter_suspend;
  assign flush_req_o = ctrl_q.flush;

endmodule

/* File: verification/udmc_main_control_asserts.sv */
`timescale 1ns/100ps

module udmc_main_control_asserts #(
  parameter int CTRL_RST_CYCLES = 16,
  parameter int BUS_RST_CYCLES = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic usb_bus_reset_i,
  input wire logic flush_done_i,
  input wire logic bus_side_reset_o,
  input wire logic controller_soft_reset_o,
  input wire logic chirp_abort_o,
  input wire logic cmd_fifo_clear_o,
  input wire logic sof_clear_o,
  input wire logic power_save_o,
  input wire logic suspend_o,
  input wire logic flush_req_o,
  input wire logic irq_o
);
  logic [7:0] cr_q;
  logic [7:0] cr_d;
  logic [7:0] br_q;
  logic [7:0] br_d;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // Pulse counters freeze with the enable, as the pulses do.
  always_comb begin
    cr_d = controller_soft_reset_o ? cr_q + {7'h00, clk_en_i} : 8'h00;
    br_d = bus_side_reset_o ? br_q + {7'h00, clk_en_i} : 8'h00;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cr_q <= 8'h00;
      br_q <= 8'h00;
    end else begin
      cr_q <= cr_d;
      br_q <= br_d;
    end
  end
  ctrl_rst_len_a: assert property ($fell(controller_soft_reset_o) |-> cr_q == 8'(CTRL_RST_CYCLES))
    else $error("controller reset pulse length wrong");
  bus_rst_len_a: assert property ($fell(bus_side_reset_o) |-> br_q == 8'(BUS_RST_CYCLES))
    else $error("bus-side reset pulse length wrong");
  rst_bundle_a: assert property ({chirp_abort_o, cmd_fifo_clear_o, sof_clear_o} == {3{controller_soft_reset_o}})
    else $error("reset side outputs disagree");
  power_drop_a: assert property (controller_soft_reset_o |-> !power_save_o)
    else $error("power save high during controller reset");
  suspend_block_a: assert property (suspend_o && $past(suspend_o) && !controller_soft_reset_o |=>
    !controller_soft_reset_o)
    else $error("controller reset started while suspended");
  power_follow_a: assert property (power_save_o |-> suspend_o)
    else $error("power save without suspend");
  power_enter_a: assert property ($rose(suspend_o) && !controller_soft_reset_o && !$past(controller_soft_reset_o)
    |-> power_save_o)
    else $error("power save not raised on suspend");
  flush_hold_a: assert property (flush_req_o && !flush_done_i |=> flush_req_o)
    else $error("flush request dropped early");
  flush_clear_a: assert property (flush_req_o && flush_done_i && clk_en_i && !(wb_cyc_i && wb_stb_i && wb_we_i)
    |=> !flush_req_o)
    else $error("flush request not cleared");
  bus_reset_susp_a: assert property ((usb_bus_reset_i && clk_en_i) [*4] |-> !suspend_o)
    else $error("suspend kept through usb bus reset");
  cover property ($fell(controller_soft_reset_o));
  cover property (flush_req_o && flush_done_i);
  cover property ($rose(irq_o));
endmodule

/* File: verification/udmc_host_model.sv */
`timescale 1ns/100ps

module udmc_host_model (
  input wire logic clk_sys_i,
  input wire logic flush_req_i,
  output logic high_speed_o,
  output logic usb_bus_reset_o,
  output logic wakeup_o,
  output logic flush_done_o
);
  int dly = 0;
  int cnt = 0;
  initial begin
    high_speed_o = 1'b0;
    usb_bus_reset_o = 1'b0;
    wakeup_o = 1'b0;
    flush_done_o = 1'b0;
  end
  task automatic set_link(input logic hs, input logic br, input logic wk);
    @(posedge clk_sys_i);
    high_speed_o <= hs;
    usb_bus_reset_o <= br;
    wakeup_o <= wk;
  endtask
  // flush completion
  // A settable delay lets a slow buffer stall the flush.
  always @(posedge clk_sys_i) begin
    flush_done_o <= 1'b0;
    if (flush_req_i && !flush_done_o) begin
      cnt <= cnt + 1;
      if (cnt >= dly) begin
        flush_done_o <= 1'b1;
        cnt <= 0;
      end
    end
  end
endmodule

/* File: verification/tb.sv */
`timescale 1ns/100ps
`include "udmc_consts.svh"

module tb;
  localparam int CTRL_RST_CYCLES = 8;
  localparam int BUS_RST_CYCLES = 3;
  localparam logic [7:0] C = `UDMC_OFS_MAIN_CTRL;
  localparam logic [7:0] S = `UDMC_OFS_IRQ_STATUS;
  localparam logic [7:0] M = `UDMC_OFS_IRQ_MASK;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] got;
  logic ack, hs, br, wk, fd, bsr, csr, psv, susp, fwe, frq, irq;
  logic en = 1'b1;
  int mask_exp[$];
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  int ctrl_m = 0;
  int mask_m = 0;
  integer seed = 32'h265b364b;
  always #12.5 clk_sys_i = ~clk_sys_i;
  udmc_main_control #(.CTRL_RST_CYCLES(CTRL_RST_CYCLES), .BUS_RST_CYCLES(BUS_RST_CYCLES)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(en), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .high_speed_i(hs), .usb_bus_reset_i(br), .wakeup_i(wk), .flush_done_i(fd),
    .bus_side_reset_o(bsr), .controller_soft_reset_o(csr), .chirp_abort_o(), .cmd_fifo_clear_o(),
    .sof_clear_o(), .power_save_o(psv), .suspend_o(susp), .fifo_write_enable_o(fwe),
    .flush_req_o(frq), .irq_o(irq));
  udmc_host_model i_host (.clk_sys_i(clk_sys_i), .flush_req_i(frq), .high_speed_o(hs),
    .usb_bus_reset_o(br), .wakeup_o(wk), .flush_done_o(fd));
  task automatic close_out();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_sys_i); while (ack !== 1'b1);
    got = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(got, e);
  endtask
  // Bounded run: a hang counts as a mismatch.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles > 20000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd(C, 32'h0);
    chk(fwe, 1'b0);
    rd(M, 32'h0);
    rd(S, 32'h0);
    for (int i = 0; i < 4; i++) begin
      mask_m = $random(seed) & 32'h3f;
      mask_exp.push_back(mask_m);
      wb(1'b1, M, $random(seed) & 32'hffffffc0 | mask_m);
      rd(M, mask_exp.pop_front());
    end
    wb(1'b1, 8'h0c, 32'hff);
    rd(8'h0c, 32'h0);
    wb(1'b1, C, 32'h65);
    ctrl_m = 32'h25;
    rd(C, ctrl_m);
    chk(fwe, 1'b1);
    i_host.set_link(1'b1, 1'b0, 1'b0);
    repeat (5) @(posedge clk_sys_i);
    ctrl_m = 32'h65;
    rd(C, ctrl_m);
    wb(1'b1, C, 32'h35);
    rd(C, 32'h75);
    wb(1'b1, C, 32'h3d);
    repeat (12) @(posedge clk_sys_i);
    ctrl_m = 32'h6d;
    rd(C, ctrl_m);
    chk(fwe, 1'b1);
    chk(psv, 1'b1);
    wb(1'b1, C, 32'h3d);
    repeat (3) @(posedge clk_sys_i);
    chk(csr, 1'b0);
    rd(C, ctrl_m);
    i_host.set_link(1'b1, 1'b0, 1'b1);
    repeat (6) @(posedge clk_sys_i);
    chk(susp, 1'b0);
    chk(psv, 1'b0);
    rd(S, 32'h29);
    wb(1'b1, C, 32'h28);
    i_host.set_link(1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge clk_sys_i);
    i_host.set_link(1'b1, 1'b0, 1'b1);
    repeat (6) @(posedge clk_sys_i);
    chk(susp, 1'b1);
    i_host.set_link(1'b1, 1'b1, 1'b0);
    repeat (6) @(posedge clk_sys_i);
    chk(susp, 1'b0);
    i_host.set_link(1'b1, 1'b0, 1'b0);
    rd(C, 32'h60);
    rd(S, 32'h10);
    wb(1'b1, C, 32'ha0);
    @(posedge clk_sys_i);
    chk(bsr, 1'b1);
    // A stopped clock must stretch the pulse, not shorten it.
    en <= 1'b0;
    repeat (($random(seed) & 7) + 2) @(posedge clk_sys_i);
    chk(bsr, 1'b1);
    en <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    rd(C, 32'h60);
    rd(S, 32'h02);
    wb(1'b1, M, 32'h04);
    for (int k = 0; k < 2; k++) begin
      i_host.dly = k * (($random(seed) & 7) + 1);
      wb(1'b1, C, 32'h26);
      chk(frq, 1'b1);
      repeat (12) @(posedge clk_sys_i);
      rd(C, 32'h64);
      chk(irq, 1'b1);
      wb(1'b1, C, 32'h20);
      repeat (2) @(posedge clk_sys_i);
      chk(irq, 1'b0);
      wb(1'b1, C, 32'h24);
      repeat (2) @(posedge clk_sys_i);
      chk(irq, 1'b1);
      wb(1'b1, M, 32'h00);
      repeat (2) @(posedge clk_sys_i);
      chk(irq, 1'b0);
      wb(1'b1, M, 32'h04);
      rd(S, 32'h04);
      repeat (2) @(posedge clk_sys_i);
      chk(irq, 1'b0);
    end
    close_out();
  end
endmodule

bind udmc_main_control udmc_main_control_asserts #(
  .CTRL_RST_CYCLES(CTRL_RST_CYCLES),
  .BUS_RST_CYCLES(BUS_RST_CYCLES)
) i_chk (
  .clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i),
  .clk_en_i(clk_en_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .usb_bus_reset_i(usb_bus_reset_i),
  .flush_done_i(flush_done_i),
  .bus_side_reset_o(bus_side_reset_o),
  .controller_soft_reset_o(controller_soft_reset_o),
  .chirp_abort_o(chirp_abort_o),
  .cmd_fifo_clear_o(cmd_fifo_clear_o),
  .sof_clear_o(sof_clear_o),
  .power_save_o(power_save_o),
  .suspend_o(suspend_o),
  .flush_req_o(flush_req_o),
  .irq_o(irq_o)
);
